// file: logic/freq_tacho_unit.sv
`timescale 1ns/1ps
module freq_tacho_unit (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// pins: input_a, manual reset, pause
	input wire logic input_a,
	input wire logic reset_in,
	input wire logic pause_in,
	// measurement settings
	input wire logic [2:0] method,
	input wire logic [4:0] debounce_ms,
	input wire logic [3:0] timeout_s,
	input wire logic [9:0] window_ds,
	input wire logic [16:0] multiplier,
	input wire logic [11:0] divisor,
	// output settings
	input wire logic [19:0] setpoint_one,
	input wire logic [19:0] setpoint_two,
	input wire logic [1:0] out1_func,
	input wire logic [1:0] alarm_type,
	input wire logic out2_hyst_mode,
	input wire logic [19:0] hyst1,
	input wire logic [19:0] hyst2,
	input wire logic pol1,
	input wire logic pol2,
	input wire logic [13:0] pulse1_ms,
	input wire logic [13:0] pulse2_ms,
	input wire logic [1:0] start_ctl,
	input wire logic [2:0] dp_code,
	// serial and panel settings
	input wire logic [7:0] slave_addr,
	input wire logic [7:0] rx_addr,
	input wire logic rx_addr_valid,
	input wire logic rtu_mode,
	input wire logic [1:0] parity_mode,
	input wire logic [2:0] baud_code,
	input wire logic two_stop,
	input wire logic [2:0] lock_code,
	input wire logic btn_reset,
	input wire logic btn_setpoint_one,
	input wire logic btn_setpoint_two,
	input wire logic [15:0] password,
	input wire logic [15:0] pwd_entry,
	input wire logic pwd_try,
	// results
	output logic [19:0] value_r,
	output logic value_valid_r,
	output logic out1_pin_r,
	output logic out2_pin_r,
	output logic [3:0] dp_r,
	output logic addr_hit_r,
	output logic baud_tick_r,
	output logic [3:0] frame_bits_r,
	output logic rst_grant_r,
	output logic setpoint_one_grant_r,
	output logic setpoint_two_grant_r,
	output logic prog_access_r
);
	logic ms_tick_r;
	logic [16:0] ms_cnt_r;
	logic [2:0] sync_r [3];
	logic [2:0] filt_r;
	logic [2:0] filt_d_r;
	logic [4:0] deb_r [3];
	logic a_rise;
	logic rst_rise;
	logic [31:0] per_r;
	logic armed_r;
	logic [16:0] win_r;
	logic [31:0] cnt_r;
	logic [13:0] tout_r;
	logic [47:0] num_r;
	logic [47:0] den_r;
	logic [47:0] quo_r;
	logic [47:0] rem_r;
	logic [5:0] bit_r;
	logic go;
	logic [47:0] go_num;
	logic [47:0] go_den;
	logic [48:0] trial;
	tach_pkg::div_t div_r;
	logic ctl_r;
	logic act1_r;
	logic act2_r;
	logic act1_d_r;
	logic act2_d_r;
	logic [13:0] pt1_r;
	logic [13:0] pt2_r;
	logic [20:0] v;
	logic [20:0] s1;
	logic [20:0] s2;
	logic alarm;
	logic [31:0] baud_r;

	// one millisecond tick drives every slow timer
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			ms_cnt_r <= '0;
		else if (ms_cnt_r == 17'(tach_pkg::MS_CYC - 1))
			ms_cnt_r <= '0;
		else
			ms_cnt_r <= ms_cnt_r + 17'h1;
	end
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			ms_tick_r <= 1'b0;
		else
			ms_tick_r <= (ms_cnt_r == 17'(tach_pkg::MS_CYC - 1));
	end

	// three-stage sync, then a ms-based debounce per pin
	for (genvar i = 0; i < 3; i++)
	begin : g_in
		logic pin;
		logic [4:0] lim;
		assign pin = (i == 0) ? input_a : (i == 1) ? reset_in : pause_in;
		// control pins never drop below the 2 ms floor
		assign lim = (i != 0 && debounce_ms < tach_pkg::RST_MIN_MS) ?
			tach_pkg::RST_MIN_MS : debounce_ms;
		always_ff @(posedge clk_sys or negedge arst_n)
		begin
			if (!arst_n)
				sync_r[i] <= '0;
			else
				sync_r[i] <= {sync_r[i][1:0], pin};
		end
		always_ff @(posedge clk_sys or negedge arst_n)
		begin
			if (!arst_n)
			begin
				filt_r[i] <= 1'b0;
				deb_r[i] <= '0;
			end
			else if (sync_r[i][1] != sync_r[i][2] || sync_r[i][2] == filt_r[i])
				deb_r[i] <= '0;
			else if (lim == 5'h00 || deb_r[i] >= lim)
			begin
				filt_r[i] <= sync_r[i][2];
				deb_r[i] <= '0;
			end
			else if (ms_tick_r)
				deb_r[i] <= deb_r[i] + 5'h1;
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			filt_d_r <= '0;
		else
			filt_d_r <= filt_r;
	end
	assign a_rise = filt_r[0] & ~filt_d_r[0];
	assign rst_rise = filt_r[1] & ~filt_d_r[1];

	// period timing between rising edges
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			per_r <= '0;
			armed_r <= 1'b0;
		end
		else if (a_rise)
		begin
			per_r <= 32'h1;
			armed_r <= 1'b1;
		end
		else if (per_r != 32'hffff_ffff)
			per_r <= per_r + 32'h1;
	end

	// counting window; pulses only counted while it runs
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			win_r <= '0;
			cnt_r <= '0;
		end
		else if (method != tach_pkg::M_COUNT || win_r == '0)
		begin
			win_r <= 17'(window_ds * tach_pkg::WIN_UNIT_MS);
			cnt_r <= '0;
		end
		else
		begin
			if (ms_tick_r)
				win_r <= win_r - 17'h1;
			if (a_rise)
				cnt_r <= cnt_r + 32'h1;
		end
	end

	// start the divider: freq scaled by multiplier over divisor
	always_comb
	begin
		go = 1'b0;
		go_num = tach_pkg::PERIOD_NUM * 48'(multiplier);
		go_den = 48'(per_r) * 48'(divisor);
		if (method == tach_pkg::M_PERIOD)
			go = a_rise && armed_r;
		else if (method == tach_pkg::M_COUNT)
		begin
			go = ms_tick_r && win_r == 17'h1 && window_ds != '0;
			go_num = tach_pkg::COUNT_NUM * 48'(cnt_r) * 48'(multiplier);
			go_den = 48'(window_ds) * 48'(divisor);
		end
	end

	// restoring divider, one quotient bit per cycle
	assign trial = {rem_r, quo_r[47]} - {1'b0, den_r};
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_r <= tach_pkg::D_IDLE;
			num_r <= '0;
			den_r <= '0;
			quo_r <= '0;
			rem_r <= '0;
			bit_r <= '0;
		end
		else
		begin
			unique case (div_r)
				tach_pkg::D_IDLE:
					if (go && !filt_r[2] && go_den != '0)
					begin
						den_r <= go_den;
						quo_r <= go_num;
						rem_r <= '0;
						bit_r <= 6'h30;
						div_r <= tach_pkg::D_RUN;
					end
				tach_pkg::D_RUN:
				begin
					if (!trial[48])
					begin
						rem_r <= trial[47:0];
						quo_r <= {quo_r[46:0], 1'b1};
					end
					else
					begin
						rem_r <= {rem_r[46:0], quo_r[47]};
						quo_r <= {quo_r[46:0], 1'b0};
					end
					bit_r <= bit_r - 6'h1;
					if (bit_r == 6'h1)
						div_r <= tach_pkg::D_DONE;
				end
				tach_pkg::D_DONE:
				begin
					num_r <= quo_r;
					div_r <= tach_pkg::D_IDLE;
				end
			endcase
		end
	end

	// displayed value, clamped to six digits; pause blocks divider starts, but the time-out still clears the value
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			value_r <= '0;
			value_valid_r <= 1'b0;
			tout_r <= '0;
		end
		else if (a_rise)
			tout_r <= '0;
		else if (timeout_s != '0 && tout_r >= 14'(timeout_s * tach_pkg::TOUT_UNIT_MS))
		begin
			value_r <= '0;
			value_valid_r <= 1'b0;
		end
		else
		begin
			if (ms_tick_r)
				tout_r <= tout_r + 14'h1;
			if (div_r == tach_pkg::D_DONE)
			begin
				value_r <= (quo_r > 48'(tach_pkg::DISP_MAX)) ? tach_pkg::DISP_MAX : quo_r[19:0];
				value_valid_r <= 1'b1;
			end
		end
	end

	// set-value comparisons
	assign v = {1'b0, value_r};
	assign s1 = {1'b0, setpoint_one};
	assign s2 = {1'b0, setpoint_two};
	always_comb
	begin
		unique case (alarm_type)
			tach_pkg::A_HIGH: alarm = v >= s1;
			tach_pkg::A_DEVHI: alarm = v >= s2 + s1;
			tach_pkg::A_DEVLO: alarm = v + s1 <= s2;
			tach_pkg::A_BAND: alarm = v >= s2 + s1 || v + s1 <= s2;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			ctl_r <= 1'b0;
		else if (start_ctl == tach_pkg::S_POWER)
			ctl_r <= 1'b1;
		else if ((start_ctl == tach_pkg::S_SP1 && v >= s1) ||
			(start_ctl == tach_pkg::S_SP2 && v >= s2))
			ctl_r <= 1'b1;
	end

	// output one activity
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			act1_r <= 1'b0;
		else if (!ctl_r)
			act1_r <= 1'b0;
		else if (out1_func == tach_pkg::F_ALARM)
			act1_r <= alarm;
		else if (out1_func == tach_pkg::F_HYST)
			act1_r <= (v >= s1) || (act1_r && v + 21'(hyst1) >= s1);
		else if (v >= s1)
			act1_r <= 1'b1;
		else if (rst_rise)
			act1_r <= 1'b0;
	end

	// output two activity
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			act2_r <= 1'b0;
		else if (!ctl_r)
			act2_r <= 1'b0;
		else if (out2_hyst_mode)
			act2_r <= (v >= s2) || (act2_r && v + 21'(hyst2) >= s2);
		else if (v >= s2)
			act2_r <= 1'b1;
		else if (rst_rise)
			act2_r <= 1'b0;
	end

	// pulse-time windows from the activation edge
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			act1_d_r <= 1'b0;
			act2_d_r <= 1'b0;
			pt1_r <= '0;
			pt2_r <= '0;
		end
		else
		begin
			act1_d_r <= act1_r;
			act2_d_r <= act2_r;
			if (act1_r && !act1_d_r)
				pt1_r <= pulse1_ms;
			else if (ms_tick_r && pt1_r != '0)
				pt1_r <= pt1_r - 14'h1;
			if (act2_r && !act2_d_r)
				pt2_r <= pulse2_ms;
			else if (ms_tick_r && pt2_r != '0)
				pt2_r <= pt2_r - 14'h1;
		end
	end
	// pin is energise xor rest polarity
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			out1_pin_r <= 1'b0;
			out2_pin_r <= 1'b0;
		end
		else
		begin
			out1_pin_r <= pol1 ^ (act1_r && (pulse1_ms == '0 || pt1_r != '0));
			out2_pin_r <= pol2 ^ (act2_r && (pulse2_ms == '0 || pt2_r != '0));
		end
	end

	// display point, serial framing, panel lock, password
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dp_r <= '0;
			addr_hit_r <= 1'b0;
			frame_bits_r <= '0;
			rst_grant_r <= 1'b0;
			setpoint_one_grant_r <= 1'b0;
			setpoint_two_grant_r <= 1'b0;
		end
		else
		begin
			dp_r <= (dp_code == 3'h0 || dp_code > 3'h4) ? 4'h0 : 4'(4'h1 << (dp_code - 3'h1));
			addr_hit_r <= rx_addr_valid && rx_addr == slave_addr &&
				slave_addr != 8'h00 && slave_addr <= tach_pkg::ADDR_MAX;
			frame_bits_r <= 4'h1 + (rtu_mode ? 4'h8 : 4'h7) +
				4'(parity_mode != 2'h0) + (two_stop ? 4'h2 : 4'h1);
			rst_grant_r <= btn_reset && lock_code != tach_pkg::L_RST &&
				lock_code != tach_pkg::L_FULL;
			setpoint_one_grant_r <= btn_setpoint_one && !(lock_code inside
				{tach_pkg::L_BOTH, tach_pkg::L_FULL, tach_pkg::L_SP1});
			setpoint_two_grant_r <= btn_setpoint_two && !(lock_code inside
				{tach_pkg::L_BOTH, tach_pkg::L_FULL, tach_pkg::L_SP2});
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			prog_access_r <= 1'b0;
		else if (password == '0)
			prog_access_r <= 1'b1;
		else if (pwd_try)
			prog_access_r <= (pwd_entry == password);
	end
	// bit-rate enable: codes above 4 fall back to the slowest rate
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			baud_r <= '0;
			baud_tick_r <= 1'b0;
		end
		else
		begin
			baud_tick_r <= 1'b0;
			if (baud_r == '0)
			begin
				baud_r <= 32'(tach_pkg::CLK_HZ /
					(tach_pkg::BAUD_BASE << ((baud_code > 3'h4) ? 3'h0 : baud_code))) - 32'h1;
				baud_tick_r <= 1'b1;
			end
			else
				baud_r <= baud_r - 32'h1;
		end
	end

	chk_tick_period: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ms_tick_r |=> !ms_tick_r [*8]) else $error("ms tick too frequent");
	chk_timeout_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(timeout_s != '0 && tout_r >= 14'(timeout_s * 1000) && !a_rise) |=> value_r == '0)
		else $error("time-out did not clear");
	chk_window_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(method == tach_pkg::M_COUNT && win_r == '0) |=> cnt_r == '0)
		else $error("count outside window");
	chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(act2_r && !out2_hyst_mode && ctl_r && !rst_rise) |=> act2_r)
		else $error("latched output dropped");
	chk_pulse_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(act1_r && pulse1_ms != '0 && pt1_r == '0 && act1_d_r) |=> out1_pin_r == pol1)
		else $error("pulse time overrun");
	chk_rest_pol: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!act2_r && !act2_d_r |=> out2_pin_r == $past(pol2))
		else $error("rest polarity wrong");
	chk_addr_match: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rx_addr_valid && rx_addr != slave_addr) |=> !addr_hit_r)
		else $error("foreign address answered");
	chk_div_len: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(div_r == tach_pkg::D_RUN) |-> ##48 div_r == tach_pkg::D_DONE)
		else $error("divider length wrong");
	chk_lock_full: assert property (@(posedge clk_sys) disable iff (!arst_n)
		lock_code == tach_pkg::L_FULL |=> !rst_grant_r && !setpoint_one_grant_r)
		else $error("full lock leaked");
	cov_value: cover property (@(posedge clk_sys) disable iff (!arst_n)
		div_r == tach_pkg::D_DONE && method == tach_pkg::M_COUNT);
	cov_alarm: cover property (@(posedge clk_sys) disable iff (!arst_n)
		out1_func == tach_pkg::F_ALARM && $rose(act1_r));
	cov_reset: cover property (@(posedge clk_sys) disable iff (!arst_n)
		rst_rise && act1_r ##1 !act1_r);
endmodule

// file: logic/tach_pkg.sv
package tach_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned MS_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam logic [4:0] RST_MIN_MS = 5'h02;
	localparam int unsigned WIN_UNIT_MS = 100;
	localparam int unsigned TOUT_UNIT_MS = 1000;
	localparam logic [47:0] PERIOD_NUM = 48'h0000_05f5_e100;
	localparam logic [47:0] COUNT_NUM = 48'h0000_0000_000a;
	localparam logic [19:0] DISP_MAX = 20'hf423f;
	localparam int unsigned BAUD_BASE = 1200;
	localparam logic [7:0] ADDR_MAX = 8'hf7;
	localparam logic [2:0] M_PERIOD = 3'h0;
	localparam logic [2:0] M_COUNT = 3'h1;
	localparam logic [1:0] F_LATCH = 2'h0;
	localparam logic [1:0] F_HYST = 2'h1;
	localparam logic [1:0] F_ALARM = 2'h2;
	localparam logic [1:0] A_HIGH = 2'h0;
	localparam logic [1:0] A_DEVHI = 2'h1;
	localparam logic [1:0] A_DEVLO = 2'h2;
	localparam logic [1:0] A_BAND = 2'h3;
	localparam logic [1:0] S_POWER = 2'h0;
	localparam logic [1:0] S_SP1 = 2'h1;
	localparam logic [1:0] S_SP2 = 2'h2;
	localparam logic [2:0] L_NONE = 3'h0;
	localparam logic [2:0] L_RST = 3'h1;
	localparam logic [2:0] L_BOTH = 3'h2;
	localparam logic [2:0] L_FULL = 3'h3;
	localparam logic [2:0] L_SP1 = 3'h4;
	localparam logic [2:0] L_SP2 = 3'h5;
	typedef enum logic [2:0] {
		D_IDLE = 3'b001,
		D_RUN = 3'b010,
		D_DONE = 3'b100
	} div_t;
endpackage

// file: verif/pulse_sensor.sv
`timescale 1ns/1ps
module pulse_sensor (
	// clock
	input wire logic clk_sys,
	// bench control
	input wire logic run,
	input wire logic [15:0] half_cyc,
	// sensor line
	output logic input_a
);
	logic level_r = 1'b0;
	logic [15:0] cnt_r = 16'h0000;
	assign input_a = level_r;
	// a stopped sensor idles low, so a restart always begins with a clean rise
	always @(posedge clk_sys)
	begin
		if (!run)
		begin
			cnt_r <= 16'h0000;
			level_r <= 1'b0;
		end
		else if (cnt_r + 16'h0001 >= half_cyc)
		begin
			cnt_r <= 16'h0000;
			level_r <= ~level_r;
		end
		else
			cnt_r <= cnt_r + 16'h0001;
	end
endmodule

// file: verif/test_freq_tacho_unit.sv
`timescale 1ns/1ps
module test_freq_tacho_unit;
	logic clk_sys, arst_n, input_a, run, reset_in, pause_in, pwd_try;
	logic [15:0] half_cyc, password, pwd_entry;
	logic [2:0] method, dp_code, baud_code, lock_code;
	logic [4:0] debounce_ms;
	logic [3:0] timeout_s, dp_r, frame_bits_r;
	logic [9:0] window_ds;
	logic [16:0] multiplier;
	logic [11:0] divisor;
	logic [19:0] setpoint_one, setpoint_two, hyst1, hyst2, value_r;
	logic [1:0] out1_func, alarm_type, start_ctl, parity_mode;
	logic [13:0] pulse1_ms, pulse2_ms;
	logic [7:0] slave_addr, rx_addr;
	logic out2_hyst_mode, pol1, pol2, rx_addr_valid, rtu_mode, two_stop;
	logic btn_reset, btn_setpoint_one, btn_setpoint_two, value_valid_r, out1_pin_r, out2_pin_r;
	logic addr_hit_r, baud_tick_r, rst_grant_r, setpoint_one_grant_r, setpoint_two_grant_r, prog_access_r;
	int fail_count, n_compared, gap;
	localparam logic [15:0] T_HALF [5] = '{16'h0014, 16'h01f4, 16'h01f4, 16'h01f4, 16'h00c8};
	localparam logic [16:0] T_MUL [5] = '{17'h00001, 17'h00001, 17'h00001, 17'h00003, 17'h00003};
	localparam logic [11:0] T_DIV [5] = '{12'h001, 12'he10, 12'h001, 12'h03c, 12'h03c};
	localparam logic [19:0] T_VAL [5] = '{20'hf423f, 20'h0001b, 20'h186a0, 20'h01388, 20'h030d4};
	localparam logic [19:0] T_SP1 [4] = '{20'h01770, 20'h001f4, 20'h001f4, 20'h007d0};
	localparam logic [19:0] T_SP2 [4] = '{20'h00000, 20'h00fa0, 20'h01770, 20'h01388};
	localparam logic T_AL [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	localparam logic [2:0] T_LOCK [6] = '{3'h7, 3'h3, 3'h4, 3'h0, 3'h5, 3'h6};
	localparam logic [3:0] T_DP [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
	localparam logic [7:0] T_SA [4] = '{8'h05, 8'h05, 8'hf7, 8'hf8};
	localparam logic [7:0] T_RX [4] = '{8'h05, 8'h06, 8'hf7, 8'hf8};
	localparam logic T_HIT [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	pulse_sensor sensor (.clk_sys, .run, .half_cyc, .input_a);
	freq_tacho_unit uut (
		.clk_sys, .arst_n, .input_a, .reset_in, .pause_in, .method, .debounce_ms,
		.timeout_s, .window_ds, .multiplier, .divisor, .setpoint_one, .setpoint_two,
		.out1_func, .alarm_type, .out2_hyst_mode, .hyst1, .hyst2, .pol1, .pol2,
		.pulse1_ms, .pulse2_ms, .start_ctl, .dp_code, .slave_addr, .rx_addr,
		.rx_addr_valid, .rtu_mode, .parity_mode, .baud_code, .two_stop, .lock_code,
		.btn_reset, .btn_setpoint_one, .btn_setpoint_two, .password, .pwd_entry, .pwd_try, .value_r,
		.value_valid_r, .out1_pin_r, .out2_pin_r, .dp_r, .addr_hit_r, .baud_tick_r,
		.frame_bits_r, .rst_grant_r, .setpoint_one_grant_r, .setpoint_two_grant_r, .prog_access_r
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// sample one step after the edge so the design's updates have landed
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task check(input logic [19:0] seen, input logic [19:0] exp, input string what);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	task wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task wait_val(input logic [19:0] exp);
		int k;
		k = 0;
		while (value_r !== exp && k < 20000)
		begin
			tick(1);
			k++;
		end
		if (k == 20000)
		begin
			check(value_r, exp, "result wait ran out");
			wrap_up();
		end
	endtask

	// cycles from one bit-rate tick to the next, bounded both ways
	task baud_gap(output int n);
		int k;
		k = 0;
		while (!baud_tick_r && k < 6000)
		begin
			tick(1);
			k++;
		end
		tick(1);
		n = 1;
		while (!baud_tick_r && n < 6000)
		begin
			tick(1);
			n++;
		end
	endtask

	task try_pwd(input logic [15:0] v);
		@(posedge clk_sys);
		pwd_entry <= v;
		pwd_try <= 1'b1;
		@(posedge clk_sys);
		pwd_try <= 1'b0;
		tick(3);
	endtask

	initial
	begin
		fail_count = 0;
		n_compared = 0;
		{arst_n, reset_in, pause_in, run, pol1, pol2, rx_addr_valid, rtu_mode} = '0;
		{two_stop, pwd_try, btn_reset, btn_setpoint_one, btn_setpoint_two, method, debounce_ms} = '0;
		{timeout_s, window_ds, dp_code, baud_code, lock_code, alarm_type, start_ctl} = '0;
		{pulse1_ms, pulse2_ms, parity_mode, password, pwd_entry, slave_addr, rx_addr} = '0;
		{hyst2, half_cyc} = '0;
		out1_func = 2'h1;
		out2_hyst_mode = 1'b1;
		hyst1 = 20'h01f40;
		setpoint_one = 20'h01770;
		setpoint_two = 20'h01770;
		multiplier = 17'h00001;
		divisor = 12'h001;
		tick(5);
		check({value_r[16:0], value_valid_r, out1_pin_r, out2_pin_r}, 20'h00000, "reset");
		@(posedge clk_sys);
		arst_n <= 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			@(posedge clk_sys);
			run <= 1'b1;
			half_cyc <= T_HALF[k];
			multiplier <= T_MUL[k];
			divisor <= T_DIV[k];
			wait_val(T_VAL[k]);
			check(value_r, T_VAL[k], "period result");
		end
		tick(4);
		check(20'(value_valid_r), 20'h00001, "result flag");
		check(20'(out1_pin_r), 20'h00001, "out1 above");
		check(20'(out2_pin_r), 20'h00001, "out2 above");
		$display("test period done");
		@(posedge clk_sys);
		half_cyc <= 16'h01f4;
		wait_val(20'h01388);
		tick(4);
		check(20'(out1_pin_r), 20'h00001, "out1 held in band");
		check(20'(out2_pin_r), 20'h00000, "out2 no band");
		@(posedge clk_sys);
		hyst1 <= 20'h00000;
		tick(4);
		check(20'(out1_pin_r), 20'h00000, "out1 band removed");
		@(posedge clk_sys);
		pol1 <= 1'b1;
		tick(4);
		check(20'(out1_pin_r), 20'h00001, "energised at rest");
		@(posedge clk_sys);
		setpoint_one <= 20'h00fa0;
		tick(4);
		check(20'(out1_pin_r), 20'h00000, "released when active");
		@(posedge clk_sys);
		pol1 <= 1'b0;
		out1_func <= 2'h2;
		$display("test hysteresis done");
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk_sys);
			alarm_type <= k[1:0];
			setpoint_one <= T_SP1[k];
			setpoint_two <= T_SP2[k];
			tick(4);
			check(20'(out1_pin_r), 20'(T_AL[k]), "alarm kind");
		end
		@(posedge clk_sys);
		out1_func <= 2'h0;
		out2_hyst_mode <= 1'b0;
		setpoint_one <= 20'h00fa0;
		setpoint_two <= 20'h00fa0;
		tick(4);
		@(posedge clk_sys);
		setpoint_one <= 20'h01770;
		setpoint_two <= 20'h01770;
		tick(4);
		check(20'(out1_pin_r), 20'h00001, "out1 latched");
		check(20'(out2_pin_r), 20'h00001, "out2 latched");
		$display("test alarm and latch done");
		@(posedge clk_sys);
		arst_n <= 1'b0;
		baud_code <= 3'h4;
		start_ctl <= 2'h2;
		out1_func <= 2'h1;
		out2_hyst_mode <= 1'b1;
		setpoint_one <= 20'h00fa0;
		tick(2);
		check(value_r, 20'h00000, "value after reset");
		@(posedge clk_sys);
		arst_n <= 1'b1;
		wait_val(20'h01388);
		tick(4);
		check(20'(out1_pin_r), 20'h00000, "control not started");
		@(posedge clk_sys);
		setpoint_two <= 20'h01194;
		tick(4);
		check(20'(out1_pin_r), 20'h00001, "control started");
		$display("test start control done");
		for (int k = 0; k < 5; k++)
		begin
			@(posedge clk_sys);
			dp_code <= k[2:0];
			tick(3);
			check(20'(dp_r), 20'(T_DP[k]), "point place");
		end
		{btn_reset, btn_setpoint_one, btn_setpoint_two} <= 3'h7;
		for (int k = 0; k < 6; k++)
		begin
			@(posedge clk_sys);
			lock_code <= k[2:0];
			tick(3);
			check(20'({rst_grant_r, setpoint_one_grant_r, setpoint_two_grant_r}), 20'(T_LOCK[k]), "lock");
		end
		$display("test panel done");
		rx_addr_valid <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk_sys);
			slave_addr <= T_SA[k];
			rx_addr <= T_RX[k];
			tick(3);
			check(20'(addr_hit_r), 20'(T_HIT[k]), "address match");
		end
		@(posedge clk_sys);
		rtu_mode <= 1'b1;
		tick(3);
		check(20'(frame_bits_r), 20'h0000a, "rtu frame");
		@(posedge clk_sys);
		rtu_mode <= 1'b0;
		parity_mode <= 2'h2;
		two_stop <= 1'b1;
		tick(3);
		check(20'(frame_bits_r), 20'h0000b, "ascii even two stops");
		baud_gap(gap);
		check(20'(gap), 20'(tach_pkg::CLK_HZ / (tach_pkg::BAUD_BASE * 16)), "bit rate");
		$display("test serial done");
		check(20'(prog_access_r), 20'h00001, "no password set");
		@(posedge clk_sys);
		password <= 16'h1234;
		try_pwd(16'h1233);
		check(20'(prog_access_r), 20'h00000, "wrong password");
		try_pwd(16'h1234);
		check(20'(prog_access_r), 20'h00001, "right password");
		$display("test password done");
		wrap_up();
	end
endmodule
